// File: tcp_pkg.sv
package tcp_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] TCP_ADDR_TUNE0 = 4'h0;
  localparam logic [3:0] TCP_ADDR_TUNE1 = 4'h1;
  localparam logic [3:0] TCP_ADDR_TUNE2 = 4'h2;
  localparam logic [3:0] TCP_ADDR_TUNE3 = 4'h3;
  localparam logic [3:0] TCP_ADDR_SYNC = 4'h4;
  localparam logic [3:0] TCP_ADDR_FILTER = 4'h5;
  localparam logic [3:0] TCP_ADDR_GAIN_FRAC = 4'h6;
  localparam logic [3:0] TCP_ADDR_GAIN_EXP = 4'h7;
  localparam logic [3:0] TCP_ADDR_OUT_FMT = 4'h8;
  localparam logic [3:0] TCP_ADDR_STATUS = 4'h9;
  localparam logic [3:0] TCP_ADDR_PULSE = 4'ha;
  localparam logic [3:0] TCP_ADDR_CHECKSUM = 4'hb;
  localparam logic [3:0] TCP_ADDR_I_LO = 4'hc;
  localparam logic [3:0] TCP_ADDR_I_HI = 4'hd;
  localparam logic [3:0] TCP_ADDR_Q_LO = 4'he;
  localparam logic [3:0] TCP_ADDR_Q_HI = 4'hf;
  localparam logic [7:0] TCP_REG_RESET = 8'h00;
  // ****************************************
  // sync control fields
  // ****************************************
  localparam int TCP_SYNC_SYSTEM_OFF = 0;
  localparam int TCP_SYNC_ACCUM_EN = 1;
  localparam int TCP_SYNC_ACCUM_FROM_SYS = 2;
  localparam int TCP_SYNC_LOAD_NOW = 3;
  localparam int TCP_SYNC_TUNE_LOAD_EN = 4;
  localparam int TCP_SYNC_DIAG_EN = 5;
  localparam int TCP_SYNC_SHORT_TEST = 6;
  localparam int TCP_SYNC_COUNTER_SEL = 7;
  // ****************************************
  // status fields, tuning word and sync counter sizes
  // ****************************************
  localparam int TCP_STAT_OVF_HOLD = 0;
  localparam int TCP_STAT_READY = 6;
  localparam int TCP_TUNE_WIDTH = 28;
  localparam int TCP_TOP_NIBBLE = 4;
  localparam int TCP_SYNC_CNT_WIDTH = 20;
  localparam int TCP_SYNC_CNT_SHORT = 8;
  localparam logic [19:0] TCP_SYNC_TC_LONG = 20'hfffff;
  localparam logic [19:0] TCP_SYNC_TC_SHORT = 20'h000ff;
  localparam logic [19:0] TCP_SYNC_CNT_ONE = 20'h00001;
endpackage : tcp_pkg

// File: tcp_control_port.sv
// Overview of operation
// - sync out is delayed system sync, or counter sync when counter select set.
// - interrupt output is the inverted ready flag of the status register.
// - any write to address 10 gives one low pulse one clock wide.
// - gain overflow drives flag low, as one-clock pulse or held level.
// - data bus driven only while chip select and read strobe low and write strobe high.
// - four-bit address selects one of sixteen unique registers.
// - read strobe and chip enable both low put addressed register on bus.
// - write strobe low at chip-enable fall loads addressed register from bus.
// - fixed map: tuning, sync, filter, gain, format, status, pulse, checksum, I, Q.
// - bits are read-only or read/write; control bits are active high.
// - 28-bit tuning word from bytes 0-2 and low nibble of byte 3.
// - sync control bit 0 makes the device ignore the system sync input.
// - accumulator free-runs unless enabled; then low accum sync reloads it.
// - bit 2 substitutes system sync for accum sync unless system sync off.
// - bit 3 copies tuning bytes to frequency register; reloads on byte change.
// - bit 4 loads frequency register when selected accumulator sync goes low.
// - bit 5 routes internal sync to checksum, accumulators and counters.
// - diagnostic sync period is 2^20 clocks, or else the system sync period.
// - bit 6 shortens the sync counter period to 2^8 clocks.
// - bit 7 takes internal sync from counter terminal count, shown on sync out.
// - system sync is sampled on rising clock edge.
module tcp_control_port
  import tcp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // host control bus
  input wire logic [3:0] ctl_addr_i,
  input wire logic [7:0] ctl_data_i,
  output logic [7:0] ctl_data_o,
  output logic ctl_data_oe_o,
  input wire logic chip_en_n_i,
  input wire logic rd_strobe_n_i,
  input wire logic wr_strobe_n_i,
  // syncs from pins
  input wire logic system_sync_n_i,
  input wire logic accum_sync_n_i,
  // datapath side
  input wire logic gain_overflow_det_i,
  input wire logic sample_ready_i,
  input wire logic [15:0] inphase_sample_i,
  input wire logic [15:0] quadrature_sample_i,
  input wire logic [7:0] checksum_i,
  // oscillator and sync controls
  output logic [27:0] osc_tuning_word_o,
  output logic osc_tuning_word_load_o,
  output logic accum_init_o,
  output logic internal_sync_o,
  output logic diag_sync_o,
  output logic [7:0] filter_control_o,
  output logic [7:0] gain_fraction_o,
  output logic [7:0] gain_exponent_o,
  output logic [7:0] output_format_o,
  // status pins
  output logic sync_out_n_o,
  output logic interrupt_n_o,
  output logic single_pulse_strobe_n_o,
  output logic gain_overflow_n_o
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [4:0] pin_meta_q;
  logic [4:0] pin_sync_q;
  logic [4:0] pin_prev_q;
  logic [3:0] addr_meta_q;
  logic [3:0] addr_q;
  logic [7:0] din_meta_q;
  logic [7:0] din_q;

  // bit order: chip_en, rd, wr, system sync, accum sync; all active low
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_q <= 5'h1f;
      pin_sync_q <= 5'h1f;
      pin_prev_q <= 5'h1f;
    end else begin
      pin_meta_q <= {chip_en_n_i, rd_strobe_n_i, wr_strobe_n_i,
                     system_sync_n_i, accum_sync_n_i};
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_meta_q <= 4'h0;
      addr_q <= 4'h0;
      din_meta_q <= 8'h00;
      din_q <= 8'h00;
    end else begin
      addr_meta_q <= ctl_addr_i;
      addr_q <= addr_meta_q;
      din_meta_q <= ctl_data_i;
      din_q <= din_meta_q;
    end
  end

  logic ce_n;
  logic rd_n;
  logic wr_n;
  logic ss_n;
  logic as_n;
  logic ce_fall;
  logic wr_pulse;
  assign ce_n = pin_sync_q[4];
  assign rd_n = pin_sync_q[3];
  assign wr_n = pin_sync_q[2];
  assign ss_n = pin_sync_q[1];
  assign as_n = pin_sync_q[0];
  assign ce_fall = pin_prev_q[4] && !ce_n;

  // write is decided at the chip-enable fall, but data is taken once both
  // strobes have been low for one settled cycle, so slow data still lands
  logic wr_armed_q;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_armed_q <= 1'b0;
    end else if (ce_n) begin
      wr_armed_q <= 1'b0;
    end else if (ce_fall && !wr_n) begin
      wr_armed_q <= 1'b1;
    end else if (wr_armed_q) begin
      wr_armed_q <= 1'b0;
    end
  end
  assign wr_pulse = wr_armed_q && !ce_n && !wr_n;

  // ****************************************
  // register file
  // ****************************************
  logic [7:0] tune_q [4];
  logic [7:0] sync_ctl_q;
  logic [7:0] filter_q;
  logic [7:0] gain_frac_q;
  logic [7:0] gain_exp_q;
  logic [7:0] out_fmt_q;
  logic ovf_hold_q;
  logic tune_changed_q;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 4; i++) begin
        tune_q[i] <= TCP_REG_RESET;
      end
      sync_ctl_q <= TCP_REG_RESET;
      filter_q <= TCP_REG_RESET;
      gain_frac_q <= TCP_REG_RESET;
      gain_exp_q <= TCP_REG_RESET;
      out_fmt_q <= TCP_REG_RESET;
      ovf_hold_q <= 1'b0;
      tune_changed_q <= 1'b0;
    end else begin
      tune_changed_q <= 1'b0;
      if (wr_pulse) begin
        case (addr_q)
          TCP_ADDR_TUNE0, TCP_ADDR_TUNE1, TCP_ADDR_TUNE2, TCP_ADDR_TUNE3: begin
            tune_q[addr_q[1:0]] <= din_q;
            tune_changed_q <= 1'b1;
          end
          TCP_ADDR_SYNC: sync_ctl_q <= din_q;
          TCP_ADDR_FILTER: filter_q <= din_q;
          TCP_ADDR_GAIN_FRAC: gain_frac_q <= din_q;
          TCP_ADDR_GAIN_EXP: gain_exp_q <= din_q;
          TCP_ADDR_OUT_FMT: out_fmt_q <= din_q;
          TCP_ADDR_STATUS: ovf_hold_q <= din_q[TCP_STAT_OVF_HOLD];
          default: ; // read-only addresses and the pulse trigger hold nothing
        endcase
      end
    end
  end

  // ****************************************
  // read path
  // ****************************************
  logic ready_q;
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (addr_q)
      TCP_ADDR_TUNE0, TCP_ADDR_TUNE1, TCP_ADDR_TUNE2, TCP_ADDR_TUNE3:
        rd_mux = tune_q[addr_q[1:0]];
      TCP_ADDR_SYNC: rd_mux = sync_ctl_q;
      TCP_ADDR_FILTER: rd_mux = filter_q;
      TCP_ADDR_GAIN_FRAC: rd_mux = gain_frac_q;
      TCP_ADDR_GAIN_EXP: rd_mux = gain_exp_q;
      TCP_ADDR_OUT_FMT: rd_mux = out_fmt_q;
      TCP_ADDR_STATUS: begin
        rd_mux[TCP_STAT_OVF_HOLD] = ovf_hold_q;
        rd_mux[TCP_STAT_READY] = ready_q;
      end
      TCP_ADDR_CHECKSUM: rd_mux = checksum_i;
      TCP_ADDR_I_LO: rd_mux = inphase_sample_i[7:0];
      TCP_ADDR_I_HI: rd_mux = inphase_sample_i[15:8];
      TCP_ADDR_Q_LO: rd_mux = quadrature_sample_i[7:0];
      TCP_ADDR_Q_HI: rd_mux = quadrature_sample_i[15:8];
      default: rd_mux = 8'h00;
    endcase
  end

  // data tracks the mux until the bus is driven: the address has settled by
  // then, and the value stays steady for the whole read
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_data_o <= 8'h00;
      ctl_data_oe_o <= 1'b0;
    end else begin
      ctl_data_oe_o <= !ce_n && !rd_n && wr_n;
      if (!ctl_data_oe_o) begin
        ctl_data_o <= rd_mux;
      end
    end
  end

  // ready sets on a new sample, clears when the last sample byte is read
  logic rd_last;
  assign rd_last = !ce_n && !rd_n && addr_q == TCP_ADDR_Q_HI && pin_prev_q[3];
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_q <= 1'b0;
      interrupt_n_o <= 1'b1;
    end else begin
      if (sample_ready_i) begin
        ready_q <= 1'b1;
      end else if (rd_last) begin
        ready_q <= 1'b0;
      end
      interrupt_n_o <= !ready_q;
    end
  end

  // ****************************************
  // single pulse and overflow
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      single_pulse_strobe_n_o <= 1'b1;
      gain_overflow_n_o <= 1'b1;
    end else begin
      single_pulse_strobe_n_o <= !(wr_pulse && addr_q == TCP_ADDR_PULSE);
      if (gain_overflow_det_i) begin
        gain_overflow_n_o <= 1'b0;
      end else if (!ovf_hold_q) begin
        gain_overflow_n_o <= 1'b1;
      end else if (wr_pulse && addr_q == TCP_ADDR_STATUS) begin
        gain_overflow_n_o <= 1'b1;
      end
    end
  end

  // ****************************************
  // sync selection
  // ****************************************
  logic system_sync_off;
  logic accum_sync_enable;
  logic accum_sync_from_system;
  logic tuning_load_now;
  logic sync_tuning_load_enable;
  logic diagnostic_sync_enable;
  logic internal_counter_sync_select;
  assign system_sync_off = sync_ctl_q[TCP_SYNC_SYSTEM_OFF];
  assign accum_sync_enable = sync_ctl_q[TCP_SYNC_ACCUM_EN];
  assign accum_sync_from_system = sync_ctl_q[TCP_SYNC_ACCUM_FROM_SYS];
  assign tuning_load_now = sync_ctl_q[TCP_SYNC_LOAD_NOW];
  assign sync_tuning_load_enable = sync_ctl_q[TCP_SYNC_TUNE_LOAD_EN];
  assign diagnostic_sync_enable = sync_ctl_q[TCP_SYNC_DIAG_EN];
  assign internal_counter_sync_select = sync_ctl_q[TCP_SYNC_COUNTER_SEL];

  logic sys_sync_act;
  logic sys_sync_fall;
  logic acc_sync_act;
  logic acc_sync_fall;
  assign sys_sync_act = !ss_n && !system_sync_off;
  assign sys_sync_fall = pin_prev_q[1] && sys_sync_act;
  assign acc_sync_act = (accum_sync_from_system && !system_sync_off) ? sys_sync_act : !as_n;
  assign acc_sync_fall = (accum_sync_from_system && !system_sync_off) ? sys_sync_fall
                         : (pin_prev_q[0] && !as_n);

  logic [19:0] sync_cnt_q;
  logic [19:0] sync_tc;
  logic counter_tc;
  assign sync_tc = sync_ctl_q[TCP_SYNC_SHORT_TEST] ? TCP_SYNC_TC_SHORT : TCP_SYNC_TC_LONG;
  // masked compare, so a switch to the short period never waits out a long wrap
  assign counter_tc = (sync_cnt_q & sync_tc) == sync_tc;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_cnt_q <= 20'h00000;
    end else if (counter_tc) begin
      sync_cnt_q <= 20'h00000;
    end else begin
      sync_cnt_q <= sync_cnt_q + TCP_SYNC_CNT_ONE;
    end
  end

  logic int_sync;
  assign int_sync = internal_counter_sync_select ? counter_tc : sys_sync_fall;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_out_n_o <= 1'b1;
      internal_sync_o <= 1'b0;
      diag_sync_o <= 1'b0;
    end else begin
      sync_out_n_o <= internal_counter_sync_select ? !counter_tc : !sys_sync_act;
      internal_sync_o <= int_sync;
      diag_sync_o <= diagnostic_sync_enable && int_sync;
    end
  end

  // ****************************************
  // oscillator frequency load
  // ****************************************
  logic [27:0] tune_word;
  assign tune_word = {tune_q[3][TCP_TOP_NIBBLE-1:0], tune_q[2], tune_q[1], tune_q[0]};
  logic load_now_prev_q;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      load_now_prev_q <= 1'b0;
      osc_tuning_word_o <= 28'h0000000;
      osc_tuning_word_load_o <= 1'b0;
      accum_init_o <= 1'b0;
    end else begin
      load_now_prev_q <= tuning_load_now;
      osc_tuning_word_load_o <= 1'b0;
      if ((tuning_load_now && (!load_now_prev_q || tune_changed_q)) ||
          (sync_tuning_load_enable && acc_sync_fall)) begin
        osc_tuning_word_o <= tune_word;
        osc_tuning_word_load_o <= 1'b1;
      end
      accum_init_o <= (accum_sync_enable && acc_sync_act) ||
                      (diagnostic_sync_enable && int_sync);
    end
  end

  // ****************************************
  // pass-through configuration
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      filter_control_o <= 8'h00;
      gain_fraction_o <= 8'h00;
      gain_exponent_o <= 8'h00;
      output_format_o <= 8'h00;
    end else begin
      filter_control_o <= filter_q;
      gain_fraction_o <= gain_frac_q;
      gain_exponent_o <= gain_exp_q;
      output_format_o <= out_fmt_q;
    end
  end
endmodule : tcp_control_port

// File: tcp_checker.sv
// ****************************************
// port protocol checks
// ****************************************
module tcp_checker (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // host strobes
  input wire logic chip_en_n_i,
  input wire logic rd_strobe_n_i,
  // datapath events
  input wire logic gain_overflow_det_i,
  input wire logic sample_ready_i,
  // watched outputs
  input wire logic [7:0] ctl_data_o,
  input wire logic ctl_data_oe_o,
  input wire logic [27:0] osc_tuning_word_o,
  input wire logic osc_tuning_word_load_o,
  input wire logic interrupt_n_o,
  input wire logic single_pulse_strobe_n_o,
  input wire logic gain_overflow_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire rd_w = !chip_en_n_i && !rd_strobe_n_i;
  // strobes pass two sync flops, so the bus may trail the pins by a few cycles
  property p_oe_cause;
    ctl_data_oe_o |-> rd_w || $past(rd_w) || $past(rd_w, 2) || $past(rd_w, 3)
      || $past(rd_w, 4) || $past(rd_w, 5);
  endproperty
  property p_oe_on; rd_w [*6] |-> ctl_data_oe_o; endproperty
  property p_rd_stable; rd_w [*6] |-> $stable(ctl_data_o); endproperty
  property p_sp_w; $fell(single_pulse_strobe_n_o) |=> single_pulse_strobe_n_o; endproperty
  property p_int_set; $rose(sample_ready_i) |-> ##[1:4] !interrupt_n_o; endproperty
  property p_int_cause;
    $fell(interrupt_n_o) |-> $past(sample_ready_i) || $past(sample_ready_i, 2)
      || $past(sample_ready_i, 3) || $past(sample_ready_i, 4);
  endproperty
  property p_ovf_set; gain_overflow_det_i |-> ##[1:4] !gain_overflow_n_o; endproperty
  property p_tuning_word_load;
    !$stable(osc_tuning_word_o) |-> ##[0:1] (osc_tuning_word_load_o || $past(osc_tuning_word_load_o));
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("bus driven without read");
  a_oe_on: assert property (p_oe_on) else $error("read not answered");
  a_rd_stable: assert property (p_rd_stable) else $error("read data moved");
  a_sp_w: assert property (p_sp_w) else $error("one-shot wider than a cycle");
  a_int_set: assert property (p_int_set) else $error("interrupt missing");
  a_int_cause: assert property (p_int_cause) else $error("interrupt without sample");
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag missing");
  a_tuning_word_load: assert property (p_tuning_word_load) else $error("frequency moved unloaded");
  c_pulse: cover property ($fell(single_pulse_strobe_n_o));
  c_read: cover property (rd_w [*6]);
  c_ovf: cover property ($fell(gain_overflow_n_o));
endmodule : tcp_checker

bind tcp_control_port tcp_checker u_chk (.ref_clk_i, .rst_n_i, .chip_en_n_i, .rd_strobe_n_i,
  .gain_overflow_det_i, .sample_ready_i, .ctl_data_o, .ctl_data_oe_o, .osc_tuning_word_o,
  .osc_tuning_word_load_o, .interrupt_n_o, .single_pulse_strobe_n_o, .gain_overflow_n_o);

// File: tcp_host_model.sv
// ****************************************
// host processor on the control bus
// ****************************************
module tcp_host_model (
  // clock
  input wire logic ref_clk_i,
  // device side
  input wire logic [7:0] dev_data_i,
  input wire logic dev_oe_i,
  // host pins
  output logic [3:0] addr_o,
  output logic [7:0] bus_o,
  output logic ce_n_o,
  output logic rd_n_o,
  output logic we_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [7:0] last_q = 8'h00;
  initial begin
    addr_o = 4'h0;
    ce_n_o = 1'b1;
    rd_n_o = 1'b1;
    we_n_o = 1'b1;
  end
  // a released bus toggles so that a stale value never reads back as good
  always_ff @(posedge ref_clk_i) last_q <= bus_o;
  assign bus_o = dev_oe_i ? dev_data_i : (drv ? wd : ~last_q);
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    addr_o = a;
    wd = d;
    drv = 1'b1;
    we_n_o = 1'b0;
    ce_n_o = 1'b0;
    repeat (6) @(negedge ref_clk_i);
    ce_n_o = 1'b1;
    we_n_o = 1'b1;
    drv = 1'b0;
    repeat (4) @(negedge ref_clk_i);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic ok);
    int k;
    @(negedge ref_clk_i);
    addr_o = a;
    rd_n_o = 1'b0;
    ce_n_o = 1'b0;
    for (k = 0; k < 10 && dev_oe_i !== 1'b1; k++) @(negedge ref_clk_i);
    ok = dev_oe_i;
    d = bus_o;
    repeat (3) @(negedge ref_clk_i);
    ce_n_o = 1'b1;
    rd_n_o = 1'b1;
    repeat (4) @(negedge ref_clk_i);
  endtask : rd
endmodule : tcp_host_model

// File: tb.sv
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("unexpected at %0t: got %h exp %h", $time, got, exp); \
    end \
  end

module tb;
  import tcp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, ce_n, rd_n, we_n, ss_n, as_n, ovf, rdy, oe, fld, ainit, so_n, int_n;
  logic sp_n, of_n, dsync, ok, isync;
  logic [3:0] addr;
  logic [7:0] bus, dout, cks, d, fctl, gfr, gex, ofmt;
  logic [15:0] iq, qq;
  logic [27:0] tuning_word;
  logic [7:0] ex [0:9];
  logic [31:0] seed = 32'h4950;
  // {sync mode, system sync, accum sync, expected init}
  logic [10:0] acc_tab [0:5] = '{11'h015, 11'h004, 11'h033, 11'h034, 11'h03a, 11'h03d};
  int err_total = 0;
  int cmp_count = 0;
  int sp_cnt = 0, of_cnt = 0, ds_cnt = 0, so_cnt = 0, fl_cnt = 0, is_cnt = 0, n, m;
  tcp_control_port u_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .ctl_addr_i(addr),
    .ctl_data_i(bus), .ctl_data_o(dout), .ctl_data_oe_o(oe), .chip_en_n_i(ce_n),
    .rd_strobe_n_i(rd_n), .wr_strobe_n_i(we_n), .system_sync_n_i(ss_n),
    .accum_sync_n_i(as_n), .gain_overflow_det_i(ovf), .sample_ready_i(rdy),
    .inphase_sample_i(iq), .quadrature_sample_i(qq), .checksum_i(cks), .osc_tuning_word_o(tuning_word),
    .osc_tuning_word_load_o(fld), .accum_init_o(ainit), .internal_sync_o(isync),
    .diag_sync_o(dsync), .filter_control_o(fctl), .gain_fraction_o(gfr),
    .gain_exponent_o(gex), .output_format_o(ofmt),
    .sync_out_n_o(so_n), .interrupt_n_o(int_n), .single_pulse_strobe_n_o(sp_n),
    .gain_overflow_n_o(of_n));
  tcp_host_model u_host (.ref_clk_i(clk), .dev_data_i(dout), .dev_oe_i(oe), .addr_o(addr),
    .bus_o(bus), .ce_n_o(ce_n), .rd_n_o(rd_n), .we_n_o(we_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    sp_cnt += (sp_n === 1'b0);
    of_cnt += (of_n === 1'b0);
    so_cnt += (so_n === 1'b0);
    ds_cnt += (dsync === 1'b1);
    fl_cnt += (fld === 1'b1);
    is_cnt += (isync === 1'b1);
  end
  function automatic logic [7:0] rnd8();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd8
  function automatic logic [7:0] rw_exp(input int a);
    return (a == 9) ? (ex[9] & 8'h01) : ex[a];
  endfunction : rw_exp
  function automatic logic [7:0] ro_exp(input int a);
    logic [39:0] ro;
    ro = {qq, iq, cks};
    return ro[(a - 11) * 8 +: 8];
  endfunction : ro_exp
  function automatic logic [27:0] tw();
    return {ex[3][3:0], ex[2], ex[1], ex[0]};
  endfunction : tw
  // tuning word for a frequency in Hz at the 100 MHz bench clock
  function automatic logic [31:0] tw_of(input longint f_hz);
    return 32'((longint'(1) << TCP_TUNE_WIDTH) * f_hz / longint'(100000000));
  endfunction : tw_of
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    u_host.rd(a, d, ok);
    `CHK(ok, 1'b1)
    if (ok !== 1'b1) begin
      finish_test();
    end else begin
      `CHK(d, e)
    end
  endtask : rd_chk
  // period of the sync out pulse, and diagnostic syncs seen within it
  task automatic per(output int p, output int dn);
    int k;
    for (k = 0; k < 600 && so_n !== 1'b0; k++) @(negedge clk);
    dn = ds_cnt;
    @(negedge clk);
    for (k = 0; k < 600 && so_n !== 1'b0; k++) @(negedge clk);
    p = k + 1;
    dn = ds_cnt - dn;
  endtask : per
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    finish_test();
  end
  initial begin
    rst_n = 1'b0;
    {ss_n, as_n, ovf, rdy} = 4'h c;
    iq = {rnd8(), rnd8()};
    qq = {rnd8(), rnd8()};
    cks = rnd8();
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    `CHK({oe, so_n, int_n, sp_n, of_n}, 5'h0f)
    for (int i = 0; i < 10; i++) ex[i] = TCP_REG_RESET;
    for (int i = 0; i < 10; i++) rd_chk(4'(i), rw_exp(i));
    for (int i = 0; i < 10; i++) begin
      ex[i] = rnd8();
      u_host.wr(4'(i), ex[i]);
    end
    for (int i = 0; i < 10; i++) rd_chk(4'(i), rw_exp(i));
    `CHK({fctl, gfr, gex, ofmt}, {ex[5], ex[6], ex[7], ex[8]})
    u_host.wr(4'hb, ~cks);
    for (int i = 11; i < 16; i++) rd_chk(4'(i), ro_exp(i));
    n = sp_cnt;
    u_host.wr(4'ha, rnd8());
    u_host.wr(4'ha, rnd8());
    `CHK(sp_cnt - n, 2)
    @(negedge clk) rdy = 1'b1;
    @(negedge clk) rdy = 1'b0;
    rd_chk(4'h9, (8'h01 << TCP_STAT_READY) | rw_exp(9));
    `CHK(int_n, 1'b0)
    rd_chk(4'hf, qq[15:8]);
    repeat (3) @(negedge clk);
    `CHK(int_n, 1'b1)
    for (int h = 0; h < 2; h++) begin
      u_host.wr(4'h9, 8'(h));
      n = of_cnt;
      @(negedge clk) ovf = 1'b1;
      @(negedge clk) ovf = 1'b0;
      repeat (8) @(negedge clk);
      `CHK({of_n, 1'(of_cnt - n == 1)}, h ? 2'b00 : 2'b11)
    end
    u_host.wr(4'h9, 8'h01);
    `CHK(of_n, 1'b1)
    {ex[3], ex[2], ex[1], ex[0]} = tw_of(longint'(rnd8()) * 390625);
    for (int i = 0; i < 4; i++) u_host.wr(4'(i), ex[i]);
    u_host.wr(4'h4, 8'h08);
    `CHK(tuning_word, tw())
    ex[2] = rnd8();
    u_host.wr(4'h2, ex[2]);
    `CHK(tuning_word, tw())
    u_host.wr(4'h4, 8'h10);
    ex[0] = ~ex[0];
    u_host.wr(4'h0, ex[0]);
    `CHK(tuning_word == tw(), 1'b0)
    n = fl_cnt;
    @(negedge clk) as_n = 1'b0;
    @(negedge clk) as_n = 1'b1;
    repeat (5) @(negedge clk);
    `CHK(tuning_word, tw())
    `CHK(fl_cnt - n, 1)
    for (int i = 0; i < 6; i++) begin
      u_host.wr(4'h4, acc_tab[i][10:3]);
      {ss_n, as_n} = acc_tab[i][2:1];
      repeat (4) @(negedge clk);
      `CHK(ainit, acc_tab[i][0])
      {ss_n, as_n} = 2'b11;
    end
    u_host.wr(4'h4, 8'h00);
    n = so_cnt;
    m = is_cnt;
    @(negedge clk) ss_n = 1'b0;
    @(negedge clk) ss_n = 1'b1;
    repeat (6) @(negedge clk);
    `CHK(so_cnt - n, 1)
    `CHK(is_cnt - m, 1)
    u_host.wr(4'h4, 8'he0);
    per(n, m);
    `CHK(n, 1 << TCP_SYNC_CNT_SHORT)
    `CHK(m, 1)
    finish_test();
  end
endmodule : tb
